// [dma_request_and_irq_routing_bench.sv]
module dma_request_and_irq_routing_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, slow = 1'b0, prev = 1'b0;
  logic [7:0] wb_adr_i = 8'h00, dma_req_o, irq_line_o, ack;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat, d;
  logic wb_ack_o, int_o, tc;
  logic [1:0] ai_lvl = 2'h0, ao_lvl = 2'h3, cnt_req = 2'h0, lvl;
  logic [5:0] src = 6'h00;
  logic [9:0] cfg;
  int seed, miscompares = 0, n_compared = 0;
  logic [5:0] idx_l[14] = '{6'h03, 6'h05, 6'h07, 6'h09, 6'h0B, 6'h0D, 6'h10, 6'h11, 6'h12,
    6'h01, 6'h0E, 6'h0F, 6'h13, 6'h3F};
  logic [31:0] msk_l[14] = '{32'h7F, 32'h7F, 32'h7F, 32'h0F, 32'h0F, 32'h3FF, 32'h07, 32'h0F,
    32'h1FF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

  always #12.5 clk_i = ~clk_i;

  dmar_top #(.NUM_PHYS(8)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ai_fifo_empty_i(ai_lvl == 2'h0),
    .ai_fifo_half_i(ai_lvl[1]), .ai_fifo_full_i(ai_lvl == 2'h3),
    .ao_fifo_empty_i(ao_lvl == 2'h0), .ao_fifo_half_i(ao_lvl[1]),
    .ao_fifo_full_i(ao_lvl == 2'h3), .cnt0_dma_req_i(cnt_req[0]), .cnt1_dma_req_i(cnt_req[1]),
    .ai_irq_i(src[0]), .cnt0_irq_i(src[1]), .ao_irq_i(src[2]), .cnt1_irq_i(src[3]),
    .dio_port_c_bit_zero_i(src[4]), .dio_port_c_bit_three_i(src[5]), .dma_ack_i(ack),
    .terminal_count_i(tc), .dma_req_o(dma_req_o), .irq_line_o(irq_line_o), .int_o(int_o)
  );
  dmar_host_model i_host (
    .clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .req_i(dma_req_o), .ack_o(ack), .tc_o(tc)
  );

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one classic cycle; the master holds everything until ack is sampled
  task automatic wb(input logic we, input logic [5:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= wd;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) miscompares++;
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
    wb(1'b0, idx, 32'h0);
    check("register", exp, rdat);
  endtask
  task automatic wait_req(input logic [7:0] m);
    for (int n = 0; n < 300 && dma_req_o !== m; n++) @(posedge clk_i);
    check("request lines", m, dma_req_o);
  endtask
  function automatic logic [7:0] exp_irq(input logic [9:0] c, input logic [5:0] s);
    logic [7:0] r;
    r = 8'h00;
    if (c[3] && (s[0] || s[1] || (c[8] && (s[4] || s[5])))) r[c[2:0]] = 1'b1;
    if (c[7] && (s[2] || s[3])) r[c[6:4]] = 1'b1;
    return r;
  endfunction
  function automatic logic fifo_req(input int o, input int c, input logic [1:0] l, input logic p);
    if (o == 0) begin
      case (c)
        0: return l != 2'h0;
        1: return l[1];
        2: return l == 2'h3;
        default: return l[1] ? 1'b1 : (l == 2'h0 ? 1'b0 : p);
      endcase
    end
    case (c)
      0: return l == 2'h0;
      1: return !l[1];
      2: return l != 2'h3;
      default: return !l[1] ? 1'b1 : (l == 2'h3 ? 1'b0 : p);
    endcase
  endfunction
  task automatic complete_run();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    seed = 65;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 14; i++) begin
      d = $random(seed);
      rd(idx_l[i], 32'h0);
      wb(1'b1, idx_l[i], (msk_l[i] == 0) ? d : d & msk_l[i]);
      rd(idx_l[i], d & msk_l[i]);
      wb(1'b1, idx_l[i], 32'h0);
    end
    $display("test register map done");
    for (int i = 0; i < 12; i++) begin
      cfg = (i == 0) ? 10'h10D : 10'($random(seed));
      wb(1'b1, 6'h0D, {22'h0, cfg});
      src <= (i == 0) ? 6'h10 : 6'($random(seed));
      repeat (6) @(posedge clk_i);
      check("irq lines", {24'h0, exp_irq(cfg, src)}, {24'h0, irq_line_o});
    end
    src <= 6'h00;
    $display("test interrupt steering done");
    wb(1'b1, 6'h03, 32'h31);
    for (int o = 0; o < 2; o++) begin
      for (int c = 0; c < 4; c++) begin
        wb(1'b1, 6'h09, o ? 32'h4 : 32'h1);
        wb(1'b1, 6'h11, 32'(c << (2 * o)));
        for (int k = 0; k < 8; k++) begin
          lvl = (k == 0) ? 2'h0 : 2'($random(seed));
          slow <= 1'($random(seed));
          if (o == 1) ao_lvl <= lvl;
          else ai_lvl <= lvl;
          prev = fifo_req(o, c, lvl, prev);
          repeat (4) @(posedge clk_i);
          check("fifo request", {24'h0, prev, 3'h0}, {24'h0, dma_req_o});
        end
      end
    end
    wb(1'b1, 6'h11, 32'h0);
    ao_lvl <= 2'h0;
    for (int e = 0; e < 2; e++) begin
      wb(1'b1, 6'h03, 32'h30 | e);
      repeat (4) @(posedge clk_i);
      check("gated request", e ? 32'h08 : 32'h0, {24'h0, dma_req_o});
    end
    $display("test fifo requests done");
    wb(1'b1, 6'h05, 32'h21);
    wb(1'b1, 6'h07, 32'h51);
    wb(1'b1, 6'h0B, 32'hE);
    for (int c = 0; c < 4; c++) begin
      cnt_req <= 2'(c);
      repeat (4) @(posedge clk_i);
      check("counter request", {26'h0, c[1], 2'h0, c[0], 2'h0} | 32'h08, {24'h0, dma_req_o});
    end
    cnt_req <= 2'h0;
    wb(1'b1, 6'h05, 32'h0);
    wb(1'b1, 6'h07, 32'h0);
    $display("test counter requests done");
    wb(1'b1, 6'h12, 32'h6);
    wb(1'b1, 6'h0F, 32'h7);
    wb(1'b1, 6'h10, 32'h1);
    wb(1'b1, 6'h0D, 32'h2F0);
    wb(1'b1, 6'h03, 32'h17);
    wait_req(8'h40);
    rd(6'h0E, 32'h1);
    check("int and line 7", 32'h180, {23'h0, int_o, irq_line_o});
    wb(1'b1, 6'h01, 32'h1);
    @(posedge clk_i);
    check("int cleared", 32'h0, {31'h0, int_o});
    rd(6'h0E, 32'h0);
    wait_req(8'h02);
    $display("test ping-pong done");
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    complete_run();
  end
endmodule

// [dmar_host_model.sv]
module dmar_host_model (
  // clock, reset, pacing
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  // dma lines
  input wire logic [7:0] req_i,
  output logic [7:0] ack_o,
  output logic tc_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int hold_q;
  int xfer_q;
  // ack held four cycles or more so the synchronisers see it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 8'h00;
      tc_o <= 1'b0;
      hold_q <= 0;
      xfer_q <= 0;
    end else if (hold_q > 0) begin
      hold_q <= hold_q - 1;
      if (hold_q == 5) begin
        ack_o <= 8'h00;
        tc_o <= 1'b0;
      end
    end else if (req_i != 8'h00) begin
      ack_o <= req_i & (~req_i + 8'h01);
      // four-word buffers keep converter pairs aligned
      tc_o <= xfer_q == 3;
      xfer_q <= (xfer_q == 3) ? 0 : xfer_q + 1;
      hold_q <= slow_i ? 16 : 9;
    end
  end
endmodule

// [dmar_pkg.sv]
package dmar_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_STROBE = 6'h01;
  localparam logic [5:0] IDX_MODE_A = 6'h03;
  localparam logic [5:0] IDX_MODE_B = 6'h05;
  localparam logic [5:0] IDX_MODE_C = 6'h07;
  localparam logic [5:0] IDX_ANA_SEL = 6'h09;
  localparam logic [5:0] IDX_CNT_SEL = 6'h0B;
  localparam logic [5:0] IDX_IRQ_CFG = 6'h0D;
  localparam logic [5:0] IDX_INT_STAT = 6'h0E;
  localparam logic [5:0] IDX_INT_CLR = 6'h0F;
  localparam logic [5:0] IDX_INT_EN = 6'h10;
  localparam logic [5:0] IDX_SRC_CFG = 6'h11;
  localparam logic [5:0] IDX_ALT_PHYS = 6'h12;

  // ----------------------------------------------------------------
  // field layouts
  // ----------------------------------------------------------------
  localparam int MODE_EN_BIT = 0;
  localparam int MODE_TCIE_BIT = 1;
  localparam int MODE_TYPE_LSB = 2;
  localparam int MODE_PHYS_LSB = 4;
  localparam logic [1:0] TYPE_DUAL = 2'h1;
  localparam int SEL_LO_LSB = 0;
  localparam int SEL_HI_LSB = 2;
  localparam int CFG_A_LINE_LSB = 0;
  localparam int CFG_A_EN_BIT = 3;
  localparam int CFG_B_LINE_LSB = 4;
  localparam int CFG_B_EN_BIT = 7;
  localparam int CFG_PTA_EN_BIT = 8;
  localparam int CFG_PTB_EN_BIT = 9;
  localparam int SRC_AI_LSB = 0;
  localparam int SRC_AO_LSB = 2;
  localparam int PHYS_W = 3;
  localparam int NUM_LCH = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [9:0] RST_CFG = 10'h000;
  localparam logic [2:0] RST_PHYS = 3'h0;

  // fifo request conditions, same code space for both directions
  typedef enum logic [1:0] {
    DMAR_FRQ_C0 = 2'h0,
    DMAR_FRQ_C1 = 2'h1,
    DMAR_FRQ_C2 = 2'h2,
    DMAR_FRQ_C3 = 2'h3
  } dmar_frq_e;

endpackage

// [dmar_top.sv]
// Behaviour
// - group one: input, counter zero, pass-through
// - group one pass-through: port C bits ORed
// - group two: output, counter one, pass-through
// - group two pass-through: enabled terminal counts
// - groups steer to lines 0-7; pass-through enables
// - three logical channels, mode registers each
// - mode: enable, interrupt enable, type, physical
// - two select registers bind sources to channels
// - request only when fully configured and requesting
// - input fifo request condition selectable
// - output fifo request condition selectable
// - buffered counters request via their own DMA request inputs
// - host terminal count raises channel interrupt
// - dual mode ping-pongs between two physical channels
// - clear strobe clears channel terminal-count status
module dmar_top #(
  parameter int NUM_PHYS = 8
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // acquisition sources, same clock
  input wire logic ai_fifo_empty_i,
  input wire logic ai_fifo_half_i,
  input wire logic ai_fifo_full_i,
  input wire logic ao_fifo_empty_i,
  input wire logic ao_fifo_half_i,
  input wire logic ao_fifo_full_i,
  input wire logic cnt0_dma_req_i,
  input wire logic cnt1_dma_req_i,
  input wire logic ai_irq_i,
  input wire logic ao_irq_i,
  input wire logic cnt0_irq_i,
  input wire logic cnt1_irq_i,
  // pins
  input wire logic dio_port_c_bit_zero_i,
  input wire logic dio_port_c_bit_three_i,
  input wire logic [NUM_PHYS-1:0] dma_ack_i,
  input wire logic terminal_count_i,
  // host requests and interrupts
  output logic [NUM_PHYS-1:0] dma_req_o,
  output logic [7:0] irq_line_o,
  output logic int_o
);
  localparam int NL = dmar_pkg::NUM_LCH;
  localparam int PW = dmar_pkg::PHYS_W;

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  generate
    if (NUM_PHYS != (1 << PW)) begin : g_bad
      $error("dmar_top: NUM_PHYS must equal 8");
    end
  endgenerate

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic [1:0] lch_code(input int ch);
    lch_code = 2'(ch + 1);
  endfunction
  function automatic logic [5:0] mode_idx(input int ch);
    case (ch)
      0: mode_idx = dmar_pkg::IDX_MODE_A;
      1: mode_idx = dmar_pkg::IDX_MODE_B;
      default: mode_idx = dmar_pkg::IDX_MODE_C;
    endcase
  endfunction
  // expand byte lanes 0 and 1 into a bit mask
  function automatic logic [15:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic ack_q;
  logic [31:0] rdat_q;
  logic [31:0] rdata_w;
  logic [5:0] idx;
  logic req_w;
  logic wr;
  logic [15:0] wm;
  logic [15:0] wd;
  assign idx = wb_adr_i[7:2];
  assign req_w = wb_cyc_i & wb_stb_i;
  // writes land on the edge that samples ack, as the master expects
  assign wr = req_w & wb_we_i & ack_q & ce_i;
  assign wm = lane_mask(wb_sel_i);
  assign wd = wb_dat_i[15:0];
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else if (ce_i) begin
      ack_q <= req_w & ~ack_q;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= '0;
    end else if (ce_i && req_w && !wb_we_i && !ack_q) begin
      rdat_q <= rdata_w;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [7:0] mode_q [NL];
  logic [7:0] ana_sel_q;
  logic [7:0] cnt_sel_q;
  logic [9:0] cfg_q;
  logic [7:0] src_q;
  logic [PW-1:0] alt_q [NL];
  logic [NL-1:0] int_en_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int ch = 0; ch < NL; ch++) begin
        mode_q[ch] <= dmar_pkg::RST_BYTE;
      end
    end else if (wr) begin
      for (int ch = 0; ch < NL; ch++) begin
        if (idx == mode_idx(ch)) begin
          mode_q[ch] <= (mode_q[ch] & ~wm[7:0]) | (wd[7:0] & wm[7:0]);
        end
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ana_sel_q <= dmar_pkg::RST_BYTE;
      cnt_sel_q <= dmar_pkg::RST_BYTE;
      src_q <= dmar_pkg::RST_BYTE;
    end else if (wr) begin
      if (idx == dmar_pkg::IDX_ANA_SEL) begin
        ana_sel_q <= (ana_sel_q & ~wm[7:0]) | (wd[7:0] & wm[7:0]);
      end
      if (idx == dmar_pkg::IDX_CNT_SEL) begin
        cnt_sel_q <= (cnt_sel_q & ~wm[7:0]) | (wd[7:0] & wm[7:0]);
      end
      if (idx == dmar_pkg::IDX_SRC_CFG) begin
        src_q <= (src_q & ~wm[7:0]) | (wd[7:0] & wm[7:0]);
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= dmar_pkg::RST_CFG;
      int_en_q <= '0;
    end else if (wr) begin
      if (idx == dmar_pkg::IDX_IRQ_CFG) begin
        cfg_q <= (cfg_q & ~wm[9:0]) | (wd[9:0] & wm[9:0]);
      end
      if (idx == dmar_pkg::IDX_INT_EN && wb_sel_i[0]) begin
        int_en_q <= wd[NL-1:0];
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int ch = 0; ch < NL; ch++) begin
        alt_q[ch] <= dmar_pkg::RST_PHYS;
      end
    end else if (wr && idx == dmar_pkg::IDX_ALT_PHYS) begin
      for (int ch = 0; ch < NL; ch++) begin
        alt_q[ch] <= (alt_q[ch] & ~wm[ch*PW +: PW]) | (wd[ch*PW +: PW] & wm[ch*PW +: PW]);
      end
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [NUM_PHYS+2:0] pin_m_q;
  logic [NUM_PHYS+2:0] pin_s_q;
  logic [NUM_PHYS-1:0] dack_s;
  logic tc_s;
  logic tc_prev_q;
  logic pc_s;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_m_q <= '0;
      pin_s_q <= '0;
      tc_prev_q <= 1'b0;
    end else if (ce_i) begin
      pin_m_q <= {dio_port_c_bit_three_i, dio_port_c_bit_zero_i,
                  terminal_count_i, dma_ack_i};
      pin_s_q <= pin_m_q;
      tc_prev_q <= tc_s;
    end
  end
  assign dack_s = pin_s_q[NUM_PHYS-1:0];
  assign tc_s = pin_s_q[NUM_PHYS];
  assign pc_s = pin_s_q[NUM_PHYS+1] | pin_s_q[NUM_PHYS+2];

  // ----------------------------------------------------------------
  // fifo request sources
  // ----------------------------------------------------------------
  logic input_fifo_request;
  logic output_fifo_request;
  logic ai_hold_q;
  logic ao_hold_q;
  dmar_pkg::dmar_frq_e ai_mode;
  dmar_pkg::dmar_frq_e ao_mode;
  assign ai_mode = dmar_pkg::dmar_frq_e'(src_q[dmar_pkg::SRC_AI_LSB +: 2]);
  assign ao_mode = dmar_pkg::dmar_frq_e'(src_q[dmar_pkg::SRC_AO_LSB +: 2]);
  // hysteresis latches for the fourth condition of each direction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ai_hold_q <= 1'b0;
      ao_hold_q <= 1'b0;
    end else if (ce_i) begin
      if (ai_fifo_half_i) begin
        ai_hold_q <= 1'b1;
      end else if (ai_fifo_empty_i) begin
        ai_hold_q <= 1'b0;
      end
      if (ao_fifo_full_i) begin
        ao_hold_q <= 1'b0;
      end else if (!ao_fifo_half_i) begin
        ao_hold_q <= 1'b1;
      end
    end
  end
  always_comb begin
    case (ai_mode)
      dmar_pkg::DMAR_FRQ_C0: input_fifo_request = ~ai_fifo_empty_i;
      dmar_pkg::DMAR_FRQ_C1: input_fifo_request = ai_fifo_half_i;
      dmar_pkg::DMAR_FRQ_C2: input_fifo_request = ai_fifo_full_i;
      default: input_fifo_request = ai_hold_q | ai_fifo_half_i;
    endcase
    case (ao_mode)
      dmar_pkg::DMAR_FRQ_C0: output_fifo_request = ao_fifo_empty_i;
      dmar_pkg::DMAR_FRQ_C1: output_fifo_request = ~ao_fifo_half_i;
      dmar_pkg::DMAR_FRQ_C2: output_fifo_request = ~ao_fifo_full_i;
      default: output_fifo_request = ao_hold_q & ~ao_fifo_full_i;
    endcase
  end

  // ----------------------------------------------------------------
  // logical to physical routing
  // ----------------------------------------------------------------
  logic [NL-1:0] lreq;
  logic [NL-1:0] use_alt_q;
  logic [NL-1:0] tc_evt;
  logic [PW-1:0] phys_w [NL];
  logic [NUM_PHYS-1:0] dreq_q;
  logic [NUM_PHYS-1:0] dreq_w;
  always_comb begin
    dreq_w = '0;
    for (int ch = 0; ch < NL; ch++) begin
      // alternate channel while the ping-pong side is active
      phys_w[ch] = use_alt_q[ch] ? alt_q[ch]
                                 : mode_q[ch][dmar_pkg::MODE_PHYS_LSB +: PW];
      // counters request through their own select register, cnt_sel_q
      lreq[ch] = mode_q[ch][dmar_pkg::MODE_EN_BIT] & (
        (ana_sel_q[dmar_pkg::SEL_LO_LSB +: 2] == lch_code(ch) & input_fifo_request) |
        (ana_sel_q[dmar_pkg::SEL_HI_LSB +: 2] == lch_code(ch) & output_fifo_request) |
        (cnt_sel_q[dmar_pkg::SEL_LO_LSB +: 2] == lch_code(ch) & cnt0_dma_req_i) |
        (cnt_sel_q[dmar_pkg::SEL_HI_LSB +: 2] == lch_code(ch) & cnt1_dma_req_i));
      // drive only the active physical line
      if (lreq[ch]) begin
        dreq_w[phys_w[ch]] = 1'b1;
      end
      // terminal count counts only with our acknowledge
      // acknowledge taken only on the active line
      tc_evt[ch] = tc_s & ~tc_prev_q & dack_s[phys_w[ch]] &
                   mode_q[ch][dmar_pkg::MODE_EN_BIT];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dreq_q <= '0;
    end else if (ce_i) begin
      dreq_q <= dreq_w;
    end
  end
  assign dma_req_o = dreq_q;
  // swap side on each terminal count in dual mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      use_alt_q <= '0;
    end else if (ce_i) begin
      for (int ch = 0; ch < NL; ch++) begin
        if (mode_q[ch][dmar_pkg::MODE_TYPE_LSB +: 2] != dmar_pkg::TYPE_DUAL) begin
          use_alt_q[ch] <= 1'b0;
        end else if (tc_evt[ch]) begin
          use_alt_q[ch] <= ~use_alt_q[ch];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // terminal-count status
  // ----------------------------------------------------------------
  logic [NL-1:0] tc_st_q;
  logic [NL-1:0] tc_clr;
  logic [NL-1:0] tc_ie;
  logic tc_irq;
  // clear via strobe register or clear register
  assign tc_clr = (wr && wb_sel_i[0] &&
                   (idx == dmar_pkg::IDX_STROBE || idx == dmar_pkg::IDX_INT_CLR))
                  ? wd[NL-1:0] : '0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tc_st_q <= '0;
    end else if (ce_i) begin
      // a new terminal count beats a clear in the same cycle
      tc_st_q <= (tc_st_q & ~tc_clr) | tc_evt;
    end
  end
  always_comb begin
    for (int ch = 0; ch < NL; ch++) begin
      tc_ie[ch] = mode_q[ch][dmar_pkg::MODE_TCIE_BIT];
    end
  end
  assign tc_irq = |(tc_st_q & tc_ie);

  // ----------------------------------------------------------------
  // interrupt groups
  // ----------------------------------------------------------------
  logic grp_a;
  logic grp_b;
  logic [7:0] line_q;
  logic int_q;
  assign grp_a = ai_irq_i | cnt0_irq_i | (cfg_q[dmar_pkg::CFG_PTA_EN_BIT] & pc_s);
  assign grp_b = ao_irq_i | cnt1_irq_i | (cfg_q[dmar_pkg::CFG_PTB_EN_BIT] & tc_irq);
  // steer each group to its selected line
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_q <= '0;
      int_q <= 1'b0;
    end else if (ce_i) begin
      for (int l = 0; l < 8; l++) begin
        line_q[l] <=
          (grp_a & cfg_q[dmar_pkg::CFG_A_EN_BIT] &
           cfg_q[dmar_pkg::CFG_A_LINE_LSB +: 3] == 3'(l)) |
          (grp_b & cfg_q[dmar_pkg::CFG_B_EN_BIT] &
           cfg_q[dmar_pkg::CFG_B_LINE_LSB +: 3] == 3'(l));
      end
      int_q <= |(tc_st_q & int_en_q);
    end
  end
  assign irq_line_o = line_q;
  assign int_o = int_q;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rdata_w = '0;
    case (idx)
      dmar_pkg::IDX_MODE_A: rdata_w[7:0] = mode_q[0];
      dmar_pkg::IDX_MODE_B: rdata_w[7:0] = mode_q[1];
      dmar_pkg::IDX_MODE_C: rdata_w[7:0] = mode_q[2];
      dmar_pkg::IDX_ANA_SEL: rdata_w[7:0] = ana_sel_q;
      dmar_pkg::IDX_CNT_SEL: rdata_w[7:0] = cnt_sel_q;
      dmar_pkg::IDX_IRQ_CFG: rdata_w[9:0] = cfg_q;
      dmar_pkg::IDX_INT_STAT: rdata_w[NL-1:0] = tc_st_q;
      dmar_pkg::IDX_INT_EN: rdata_w[NL-1:0] = int_en_q;
      dmar_pkg::IDX_SRC_CFG: rdata_w[7:0] = src_q;
      dmar_pkg::IDX_ALT_PHYS: rdata_w[NL*PW-1:0] = {alt_q[2], alt_q[1], alt_q[0]};
      default: rdata_w = '0;
    endcase
  end

endmodule

// [dmar_top_assertions.sv]
module dmar_top_assertions #(
  parameter int NUM_PHYS = 8
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // host side
  input wire logic [NUM_PHYS-1:0] dma_req_o,
  input wire logic [7:0] irq_line_o,
  input wire logic int_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic take;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;

  property p_ack_lat;
    take |=> wb_ack_o;
  endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");
  property p_ack_pulse;
    wb_ack_o && ce_i |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_no_stray_ack;
    !wb_cyc_i && !wb_ack_o |=> !wb_ack_o;
  endproperty
  a_no_stray_ack: assert property (p_no_stray_ack) else $error("stray ack");
  property p_unmapped;
    take && !wb_we_i && wb_adr_i[7:2] > 6'h12 |=> wb_dat_o == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not 0");
  property p_wo_zero;
    take && !wb_we_i && (wb_adr_i[7:2] == 6'h01 || wb_adr_i[7:2] == 6'h0F)
      |=> wb_dat_o == 32'h00000000;
  endproperty
  a_wo_zero: assert property (p_wo_zero) else $error("strobe read not 0");
  property p_rd_hold;
    !(take && !wb_we_i) |=> $stable(wb_dat_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_req_max;
    $countones(dma_req_o) <= 3;
  endproperty
  a_req_max: assert property (p_req_max) else $error("too many requests");
  property p_irq_two;
    $countones(irq_line_o) <= 2;
  endproperty
  a_irq_two: assert property (p_irq_two) else $error("too many irq lines");
  property p_rel_quiet;
    $fell(rst_i) |-> dma_req_o == '0 && irq_line_o == 8'h00 && !int_o;
  endproperty
  a_rel_quiet: assert property (p_rel_quiet) else $error("busy after reset");
endmodule

bind dmar_top dmar_top_assertions #(.NUM_PHYS(NUM_PHYS)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .dma_req_o(dma_req_o), .irq_line_o(irq_line_o), .int_o(int_o)
);
